// ### hdl/clf_host_rx.sv
// Host end of the logger's serial link: byte receiver, frame hunter,
// destuffer, checksum check, payload FIFO and message field capture.
// Assumes ser_rxd is the logger's serial output, synchronous to sys_clk,
// and the consumer drains the payload through pay_valid/pay_ready.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Line runs 115200 bit/s, 8N1, no flow
// - Flag value appears only at frame boundaries
// - Only bytes between flags build a frame
// - Escape byte dropped; next byte bit five flipped
// - Checksum covers destuffed payload bytes only
// - Checksum travels high byte first
// - Frame good only when checksums match
// - Checksum polynomial 0x8005, sixteen bits
// - Payload opens with one-byte application identifier
// - Identifier 1 received, 2 transmitted message
// - Timestamp counts seconds since Unix epoch
// - Message identifier extended when bit 29 set
// - Multi-byte fields arrive most significant first
module clf_host_rx (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ser_rxd,
  output logic [7:0] pay_data,
  output logic pay_first,
  output logic pay_valid,
  input wire logic pay_ready,
  output logic frame_done,
  output logic frame_ok,
  output logic [7:0] app_id,
  output logic kind_rx,
  output logic kind_tx,
  output logic [31:0] time_sec,
  output logic [28:0] msg_id,
  output logic msg_ext,
  output logic rx_overrun,
  output logic rx_frame_err
);
  ////////////////////////////////////////////////////////////////////////////////
  // Byte receiver and payload FIFO

  clf_byte_if #(.W(8)) rx_if ();
  clf_byte_if #(.W(clf_pkg::FIFO_W)) fifo_in_if ();
  clf_byte_if #(.W(clf_pkg::FIFO_W)) fifo_out_if ();

  clf_uart_rx u_rx (
    .sys_clk(sys_clk),
    .rst(rst),
    .ser_rxd(ser_rxd),
    .out_if(rx_if),
    .overrun(rx_overrun),
    .frame_err(rx_frame_err)
  );

  clf_fifo #(.W(clf_pkg::FIFO_W), .DEPTH(clf_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_if(fifo_in_if),
    .out_if(fifo_out_if)
  );

  assign pay_data = fifo_out_if.data[7:0];
  assign pay_first = fifo_out_if.data[8];
  assign pay_valid = fifo_out_if.valid;
  assign fifo_out_if.ready = pay_ready;

  ////////////////////////////////////////////////////////////////////////////////
  // Field position decode, used for both captured words

  function automatic logic in_field(input logic [7:0] idx, input logic [7:0] first);
    return (idx >= first) && (idx < first + clf_pkg::FIELD_LEN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Deframer state and byte classification

  clf_pkg::clf_df_e st_r;
  clf_pkg::clf_df_e st_nxt;
  logic [7:0] nbytes_r;
  logic [7:0] nbytes_nxt;
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;
  logic [7:0] sh1_r;
  logic [7:0] sh0_r;
  logic [7:0] id_sh_r;
  logic [31:0] time_sh_r;
  logic [31:0] mid_sh_r;
  logic done_r;
  logic ok_r;
  logic [7:0] app_id_r;
  logic kind_rx_r;
  logic kind_tx_r;
  logic [31:0] time_r;
  logic [31:0] mid_r;
  logic ext_r;

  wire [7:0] in_data = rx_if.data;
  wire is_flag = (in_data == clf_pkg::FLAG_BYTE);
  wire is_esc = (in_data == clf_pkg::ESC_BYTE);
  wire in_body = (st_r == clf_pkg::DF_BODY);
  wire in_esc = (st_r == clf_pkg::DF_ESC);
  wire data_byte = (in_body && !is_flag && !is_esc) || (in_esc && !is_flag);
  wire [7:0] dval = in_esc ? (in_data ^ clf_pkg::ESC_FLIP) : in_data;
  // The two newest bytes may be the checksum, so payload lags by two
  wire have2 = (nbytes_r >= 8'h02);
  wire [7:0] pidx = nbytes_r - 8'h02;
  wire push = rx_if.valid && data_byte && have2;
  wire take = rx_if.valid && rx_if.ready;
  wire step = take && data_byte && have2;
  wire restart = take && is_flag;
  wire close_good = take && is_flag && in_body && (nbytes_r >= clf_pkg::MIN_FRAME);
  wire crc_match = (crc_r == {sh1_r, sh0_r});

  // Full FIFO stalls the deframer; the receiver flags overrun if the next byte completes during the stall
  assign rx_if.ready = !(data_byte && have2 && !fifo_in_if.ready);
  assign fifo_in_if.valid = push;
  assign fifo_in_if.data = {pidx == clf_pkg::POS_APP_ID, sh1_r};

  always_comb begin
    st_nxt = st_r;
    if (take) begin
      case (st_r)
        clf_pkg::DF_HUNT: if (is_flag) st_nxt = clf_pkg::DF_BODY;
        clf_pkg::DF_BODY: if (is_esc) st_nxt = clf_pkg::DF_ESC;
        // A flag right after an escape aborts and reopens
        clf_pkg::DF_ESC: st_nxt = clf_pkg::DF_BODY;
        default: st_nxt = clf_pkg::DF_HUNT;
      endcase
    end
  end

  always_comb begin
    nbytes_nxt = nbytes_r;
    if (restart) begin
      nbytes_nxt = 8'h00;
    end else if (take && data_byte && nbytes_r != clf_pkg::CNT_MAX) begin
      nbytes_nxt = nbytes_r + 8'h01;
    end
  end

  always_comb begin
    crc_nxt = crc_r;
    if (restart) begin
      crc_nxt = clf_pkg::CRC_INIT;
    end else if (step) begin
      crc_nxt = clf_pkg::crc16_byte(crc_r, sh1_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Deframer registers

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= clf_pkg::DF_HUNT;
      nbytes_r <= 8'h00;
      crc_r <= clf_pkg::CRC_INIT;
    end else begin
      st_r <= st_nxt;
      nbytes_r <= nbytes_nxt;
      crc_r <= crc_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sh1_r <= 8'h00;
      sh0_r <= 8'h00;
    end else if (take && data_byte) begin
      sh1_r <= sh0_r;
      sh0_r <= dval;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Message field capture, high byte first

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      id_sh_r <= 8'h00;
      time_sh_r <= 32'h0000_0000;
      mid_sh_r <= 32'h0000_0000;
    end else if (step) begin
      if (pidx == clf_pkg::POS_APP_ID) id_sh_r <= sh1_r;
      if (in_field(pidx, clf_pkg::POS_TIME)) time_sh_r <= {time_sh_r[23:0], sh1_r};
      if (in_field(pidx, clf_pkg::POS_MSG_ID)) mid_sh_r <= {mid_sh_r[23:0], sh1_r};
    end
  end

  // Outputs keep the last good frame; a bad one pulses done and clears ok
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      done_r <= 1'b0;
      ok_r <= 1'b0;
      app_id_r <= 8'h00;
      kind_rx_r <= 1'b0;
      kind_tx_r <= 1'b0;
      time_r <= 32'h0000_0000;
      mid_r <= 32'h0000_0000;
      ext_r <= 1'b0;
    end else begin
      done_r <= close_good;
      if (close_good) ok_r <= crc_match;
      if (close_good && crc_match) begin
        app_id_r <= id_sh_r;
        kind_rx_r <= (id_sh_r == clf_pkg::APP_ID_RX);
        kind_tx_r <= (id_sh_r == clf_pkg::APP_ID_TX);
        time_r <= time_sh_r;
        mid_r <= mid_sh_r;
        ext_r <= mid_sh_r[clf_pkg::EXT_BIT];
      end
    end
  end

  assign frame_done = done_r;
  assign frame_ok = ok_r;
  assign app_id = app_id_r;
  assign kind_rx = kind_rx_r;
  assign kind_tx = kind_tx_r;
  assign time_sec = time_r;
  // Standard identifiers use only the low bits; upper bits pass as sent
  assign msg_id = mid_r[28:0];
  assign msg_ext = ext_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_hunt_quiet;
    @(posedge sys_clk) disable iff (rst)
    (st_r == clf_pkg::DF_HUNT) |-> !fifo_in_if.valid && !close_good;
  endproperty
  a_hunt_quiet: assert property (p_hunt_quiet) else $error("payload outside a frame");

  property p_esc_drop;
    @(posedge sys_clk) disable iff (rst)
    (take && in_body && is_esc) |=> (st_r == clf_pkg::DF_ESC) && $stable(nbytes_r);
  endproperty
  a_esc_drop: assert property (p_esc_drop) else $error("escape byte not dropped");

  property p_esc_restore;
    @(posedge sys_clk) disable iff (rst)
    (take && in_esc && !is_flag) |=> (sh0_r == ($past(in_data) ^ clf_pkg::ESC_FLIP));
  endproperty
  a_esc_restore: assert property (p_esc_restore) else $error("escaped byte not restored");

  property p_crc_restart;
    @(posedge sys_clk) disable iff (rst)
    restart |=> (crc_r == clf_pkg::CRC_INIT) && (nbytes_r == 8'h00);
  endproperty
  a_crc_restart: assert property (p_crc_restart) else $error("checksum not cleared at flag");

  property p_crc_only_payload;
    @(posedge sys_clk) disable iff (rst)
    (!step && !restart) |=> $stable(crc_r);
  endproperty
  a_crc_only_payload: assert property (p_crc_only_payload) else $error("checksum moved");

  property p_verdict;
    @(posedge sys_clk) disable iff (rst)
    close_good |=> frame_done && (frame_ok == ($past(crc_r) == {$past(sh1_r), $past(sh0_r)}));
  endproperty
  a_verdict: assert property (p_verdict) else $error("frame verdict wrong");

  property p_kind;
    @(posedge sys_clk) disable iff (rst)
    (frame_done && frame_ok) |-> (kind_rx == (app_id == clf_pkg::APP_ID_RX))
      && (kind_tx == (app_id == clf_pkg::APP_ID_TX));
  endproperty
  a_kind: assert property (p_kind) else $error("message kind mismatch");

  property p_ext;
    @(posedge sys_clk) disable iff (rst)
    (close_good && crc_match) |=> (msg_ext == $past(mid_sh_r[clf_pkg::EXT_BIT]))
      && (msg_id == $past(mid_sh_r[28:0]));
  endproperty
  a_ext: assert property (p_ext) else $error("extended flag wrong");

  property p_msb_first;
    @(posedge sys_clk) disable iff (rst)
    (step && pidx == clf_pkg::POS_TIME) |=> (time_sh_r[7:0] == $past(sh1_r))
      && (time_sh_r[15:8] == $past(time_sh_r[7:0]));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("field byte order wrong");

  // Opening flags after a closing flag land here and must stay silent
  property p_short_silent;
    @(posedge sys_clk) disable iff (rst)
    (take && is_flag && in_body && nbytes_r < clf_pkg::MIN_FRAME) |=> !frame_done;
  endproperty
  a_short_silent: assert property (p_short_silent) else $error("short frame reported");

  property p_time_load;
    @(posedge sys_clk) disable iff (rst)
    (close_good && crc_match) |=> (time_sec == $past(time_sh_r));
  endproperty
  a_time_load: assert property (p_time_load) else $error("seconds not loaded");

  property p_app_id_load;
    @(posedge sys_clk) disable iff (rst)
    (close_good && crc_match) |=> (app_id == $past(id_sh_r));
  endproperty
  a_app_id_load: assert property (p_app_id_load) else $error("identifier not loaded");
endmodule // clf_host_rx

// ### hdl/clf_pkg.sv
// Constants, types and the checksum step shared by the serial log host receiver.
// Assumes one 10 MHz clock; the serial line is taken as synchronous to it.
package clf_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned BAUD_BPS = 115200;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD_BPS;
  localparam int unsigned HALF_CYC = BIT_CYC / 2;
  localparam logic [7:0] BIT_RELOAD = 8'(BIT_CYC - 1);
  localparam logic [7:0] HALF_RELOAD = 8'(HALF_CYC - 1);
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] FLAG_BYTE = 8'h7E;
  localparam logic [7:0] ESC_BYTE = 8'h7D;
  localparam logic [7:0] ESC_FLIP = 8'h20;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_POLY_REFL = 16'hA001;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [7:0] APP_ID_RX = 8'h01;
  localparam logic [7:0] APP_ID_TX = 8'h02;
  localparam logic [7:0] POS_APP_ID = 8'h00;
  localparam logic [7:0] POS_TIME = 8'h01;
  localparam logic [7:0] POS_MSG_ID = 8'h05;
  localparam logic [7:0] FIELD_LEN = 8'h04;
  localparam logic [7:0] MIN_FRAME = 8'h03;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam int unsigned EXT_BIT = 29;
  localparam int unsigned FIFO_W = 9;
  localparam int unsigned FIFO_DEPTH = 16;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000
  } clf_rx_e;

  typedef enum logic [2:0] {
    DF_HUNT = 3'b001, DF_BODY = 3'b010, DF_ESC = 3'b100
  } clf_df_e;

  // Reflected form, LSB of each byte first
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction
endpackage

// ### hdl/clf_byte_if.sv
// Valid/ready word carrier between the receiver's own modules.
// Assumes source and sink share sys_clk.
`timescale 1ns/1ps
interface clf_byte_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface // clf_byte_if

// ### hdl/clf_uart_rx.sv
// Serial line receiver, 8 data bits LSB first, 1 stop bit, no parity.
// Assumes ser_rxd is synchronous to sys_clk and idles high.
`timescale 1ns/1ps
module clf_uart_rx (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ser_rxd,
  clf_byte_if.src out_if,
  output logic overrun,
  output logic frame_err
);
  clf_pkg::clf_rx_e st_r;
  logic [7:0] cnt_r;
  logic [2:0] bit_r;
  logic [7:0] sh_r;
  logic [7:0] hold_r;
  logic valid_r;
  logic ovr_r;
  logic ferr_r;
  wire tick = (cnt_r == 8'h00);
  wire got = (st_r == clf_pkg::RX_STOP) && tick && ser_rxd;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= clf_pkg::RX_IDLE;
      cnt_r <= 8'h00;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
    end else begin
      cnt_r <= tick ? 8'h00 : cnt_r - 8'h01;
      case (st_r)
        clf_pkg::RX_IDLE: if (!ser_rxd) begin
          st_r <= clf_pkg::RX_START;
          cnt_r <= clf_pkg::HALF_RELOAD;
        end
        clf_pkg::RX_START: if (tick) begin
          // A high line at mid start bit was a glitch
          st_r <= ser_rxd ? clf_pkg::RX_IDLE : clf_pkg::RX_DATA;
          cnt_r <= clf_pkg::BIT_RELOAD;
          bit_r <= 3'h0;
        end
        clf_pkg::RX_DATA: if (tick) begin
          sh_r <= {ser_rxd, sh_r[7:1]};
          bit_r <= bit_r + 3'h1;
          cnt_r <= clf_pkg::BIT_RELOAD;
          if (bit_r == clf_pkg::LAST_BIT) st_r <= clf_pkg::RX_STOP;
        end
        clf_pkg::RX_STOP: if (tick) st_r <= clf_pkg::RX_IDLE;
        default: st_r <= clf_pkg::RX_IDLE;
      endcase
    end
  end

  // No flow control on the line: a byte that finds the holding slot busy is lost
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_r <= 8'h00;
      valid_r <= 1'b0;
      ovr_r <= 1'b0;
      ferr_r <= 1'b0;
    end else begin
      ovr_r <= got && valid_r && !out_if.ready;
      ferr_r <= (st_r == clf_pkg::RX_STOP) && tick && !ser_rxd;
      if (got && !(valid_r && !out_if.ready)) begin
        hold_r <= sh_r;
        valid_r <= 1'b1;
      end else if (out_if.ready) begin
        valid_r <= 1'b0;
      end
    end
  end

  assign out_if.data = hold_r;
  assign out_if.valid = valid_r;
  assign overrun = ovr_r;
  assign frame_err = ferr_r;

  property p_half_bit;
    @(posedge sys_clk) disable iff (rst)
    (st_r == clf_pkg::RX_IDLE && !ser_rxd) |-> ##44 (st_r != clf_pkg::RX_START);
  endproperty
  a_half_bit: assert property (p_half_bit) else $error("start bit not resolved at mid bit");
endmodule // clf_uart_rx

// ### hdl/clf_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/1ps
module clf_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  clf_byte_if.snk in_if,
  clf_byte_if.src out_if
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  wire [AW:0] used = wr_r - rd_r;
  wire full = (used == (AW+1)'(DEPTH));
  wire empty = (used == '0);
  wire wr_go = in_if.valid && !full;
  wire rd_go = out_if.ready && !empty;

  always_ff @(posedge sys_clk) begin
    if (wr_go) mem[wr_r[AW-1:0]] <= in_if.data;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (wr_go) wr_r <= wr_r + (AW+1)'(1);
      if (rd_go) rd_r <= rd_r + (AW+1)'(1);
    end
  end

  assign in_if.ready = !full;
  assign out_if.valid = !empty;
  assign out_if.data = mem[rd_r[AW-1:0]];

  property p_bounded;
    @(posedge sys_clk) disable iff (rst)
    (used <= (AW+1)'(DEPTH)) and (full |=> (wr_r == $past(wr_r)));
  endproperty
  a_bounded: assert property (p_bounded) else $error("fifo written while full");
endmodule // clf_fifo

// ### verif/clf_logger_model.sv
// Behavioural model of the logger's serial transmit side.
// Assumes the bench fills pay_q and calls the tasks just after a falling edge.
`timescale 1ns/1ps
module clf_logger_model #(
  parameter int BIT_CYC = 86
) (
  input wire logic sys_clk,
  output logic ser_rxd
);
  logic [7:0] pay_q[$];
  int gap_cyc = 0;

  // Line idles until the bench starts traffic after boot
  initial ser_rxd = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // 8N1, LSB first; a low stop_ok makes a broken stop bit
  task automatic send_byte(input logic [7:0] b, input logic stop_ok = 1'b1);
    ser_rxd = 1'b0;
    wait_cyc(BIT_CYC);
    for (int i = 0; i < 8; i++) begin
      ser_rxd = b[i];
      wait_cyc(BIT_CYC);
    end
    ser_rxd = stop_ok;
    wait_cyc(BIT_CYC);
    ser_rxd = 1'b1;
    // At least one idle cycle before the next start bit
    wait_cyc(gap_cyc + 1);
  endtask

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
    end
    return r;
  endfunction

  task automatic send_stuffed(input logic [7:0] b);
    if (b == 8'h7E || b == 8'h7D) begin
      send_byte(8'h7D);
      send_byte(b ^ 8'h20);
    end else begin
      send_byte(b);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // A bad checksum is sent only when the bench asks for it
  task automatic send_frame(input logic bad_crc);
    logic [15:0] crc;
    crc = 16'h0000;
    send_byte(8'h7E);
    foreach (pay_q[i]) begin
      crc = crc_step(crc, pay_q[i]);
      send_stuffed(pay_q[i]);
    end
    if (bad_crc) begin
      crc = ~crc;
    end
    send_stuffed(crc[15:8]);
    send_stuffed(crc[7:0]);
    send_byte(8'h7E);
    pay_q.delete();
  endtask
endmodule // clf_logger_model

// ### verif/can_log_serial_framer_tb_top.sv
// Self-checking bench for the host receiver of the logger's serial link.
// Assumes the logger model drives ser_rxd and the bench drains the payload.
`timescale 1ns/1ps
module can_log_serial_framer_tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ser_rxd;
  logic pay_ready = 1'b0;
  logic [7:0] pay_data;
  logic pay_first, pay_valid, frame_done, frame_ok, kind_rx, kind_tx, msg_ext;
  logic rx_overrun, rx_frame_err;
  logic [7:0] app_id;
  logic [31:0] time_sec;
  logic [28:0] msg_id;
  int err_count = 0;
  int comparisons = 0;
  int done_cnt = 0;
  int ferr_cnt = 0;
  int ovr_cnt = 0;
  logic ok_seen = 1'b0;
  logic [7:0] exp_q[$];

  always #50 sys_clk = ~sys_clk;

  clf_host_rx dut (
    .sys_clk(sys_clk), .rst(rst), .ser_rxd(ser_rxd),
    .pay_data(pay_data), .pay_first(pay_first), .pay_valid(pay_valid),
    .pay_ready(pay_ready), .frame_done(frame_done), .frame_ok(frame_ok),
    .app_id(app_id), .kind_rx(kind_rx), .kind_tx(kind_tx), .time_sec(time_sec),
    .msg_id(msg_id), .msg_ext(msg_ext), .rx_overrun(rx_overrun),
    .rx_frame_err(rx_frame_err)
  );

  clf_logger_model partner (.sys_clk(sys_clk), .ser_rxd(ser_rxd));

  // Pulses are one cycle wide, so they are counted as they pass
  always @(posedge sys_clk) begin
    if (frame_done === 1'b1) begin
      done_cnt <= done_cnt + 1;
      ok_seen <= frame_ok;
    end
    if (rx_frame_err === 1'b1) begin
      ferr_cnt <= ferr_cnt + 1;
    end
    if (rx_overrun === 1'b1) begin
      ovr_cnt <= ovr_cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (err_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic put(input logic [7:0] b);
    partner.pay_q.push_back(b);
    exp_q.push_back(b);
  endtask

  task automatic put32(input logic [31:0] w);
    for (int i = 3; i >= 0; i--) begin
      put(w[8*i +: 8]);
    end
  endtask

  task automatic frame(input logic bad, input logic exp_ok);
    int n0;
    n0 = done_cnt;
    partner.send_frame(bad);
    repeat (2) @(negedge sys_clk);
    check(done_cnt - n0, 1, "frame end count");
    check(ok_seen, exp_ok, "frame verdict");
    check(ovr_cnt, 0, "no byte lost");
  endtask

  task automatic fields(input logic [7:0] a, input logic [31:0] t, input logic [31:0] m);
    check(app_id, a, "app id");
    check(kind_rx, a == 8'h01, "received kind");
    check(kind_tx, a == 8'h02, "sent kind");
    check(time_sec, t, "seconds");
    check(msg_id, m[28:0], "message id");
    check(msg_ext, m[29], "extended id");
  endtask

  // One stall cycle after every byte taken
  task automatic drain();
    int k;
    int t;
    k = 0;
    while (exp_q.size() > 0) begin
      t = 0;
      while (pay_valid !== 1'b1 && t < 50) begin
        @(negedge sys_clk);
        t++;
      end
      check(pay_data, exp_q[0], "payload byte");
      check(pay_first, k == 0, "first byte mark");
      pay_ready = 1'b1;
      @(negedge sys_clk);
      pay_ready = 1'b0;
      @(negedge sys_clk);
      void'(exp_q.pop_front());
      k++;
    end
    check(pay_valid, 1'b0, "payload empty");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Junk before the flag, escapes in fields and data, extended id
  task automatic sc_rx_ext();
    partner.send_byte(8'h55);
    put(8'h01);
    put32(32'h7E7D_1234);
    put32(32'h2000_07E5);
    put(8'h7E);
    put(8'h7D);
    frame(1'b0, 1'b1);
    fields(8'h01, 32'h7E7D_1234, 32'h2000_07E5);
    drain();
  endtask

  // Slow logger pacing, standard id
  task automatic sc_tx_std();
    partner.gap_cyc = 300;
    put(8'h02);
    put32(32'h5F00_0001);
    put32(32'h0000_0123);
    put(8'h11);
    frame(1'b0, 1'b1);
    partner.gap_cyc = 0;
    fields(8'h02, 32'h5F00_0001, 32'h0000_0123);
    drain();
  endtask

  // Bad checksum keeps the previous good fields
  task automatic sc_bad_crc();
    put(8'h01);
    put32(32'h0000_00AA);
    put32(32'h1FFF_FFFF);
    frame(1'b1, 1'b0);
    fields(8'h02, 32'h5F00_0001, 32'h0000_0123);
    drain();
  endtask

  // Sixteen payload bytes fill the buffer while the consumer holds off
  task automatic sc_fill();
    put(8'h01);
    put32(32'h0102_0304);
    put32(32'h2123_4567);
    for (int i = 0; i < 7; i++) begin
      put(8'hA0 + 8'(i));
    end
    frame(1'b0, 1'b1);
    check(pay_valid, 1'b1, "buffer holds");
    fields(8'h01, 32'h0102_0304, 32'h2123_4567);
    drain();
  endtask

  task automatic sc_stop_err();
    int n0;
    int d0;
    n0 = ferr_cnt;
    d0 = done_cnt;
    partner.send_byte(8'hC3, 1'b0);
    repeat (2) @(negedge sys_clk);
    check(ferr_cnt - n0, 1, "stop bit error");
    check(done_cnt - d0, 0, "no frame end");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge sys_clk);
    check(pay_valid, 1'b0, "reset empty");
    check(frame_ok, 1'b0, "reset verdict");
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    sc_rx_ext();
    sc_tx_std();
    sc_bad_crc();
    sc_fill();
    sc_stop_err();
    give_verdict();
  end

  initial begin
    repeat (90000) @(posedge sys_clk);
    err_count++;
    $display("ERROR %0t: run did not finish in time", $time);
    give_verdict();
  end
endmodule // can_log_serial_framer_tb_top
